// ==== include/gpio_change_pkg.sv ====
// Constants shared by the eight-bit port with change detection
package gpio_change_pkg;
  localparam int unsigned PORT_W = 8;
  localparam int unsigned ADDR_W = 8;
  // Register byte addresses on the bus
  localparam logic [7:0] ADDR_PIN_VALUE = 8'h00;
  localparam logic [7:0] ADDR_OUT_LATCH = 8'h04;
  localparam logic [7:0] ADDR_DIRECTION = 8'h08;
  localparam logic [7:0] ADDR_INT_MAIN = 8'h0c;
  localparam logic [7:0] ADDR_INT_SECOND = 8'h10;
  localparam logic [7:0] ADDR_INT_THIRD = 8'h14;
  localparam logic [7:0] ADDR_PROG_CTRL = 8'h18;
  // Field positions
  localparam int unsigned CHANGE_FLAG_BIT = 0;
  localparam int unsigned CHANGE_ENABLE_BIT = 3;
  localparam int unsigned PULLUP_DIS_N_BIT = 7;
  localparam int unsigned CHANGE_PRIO_BIT = 0;
  localparam int unsigned PROG_ENABLE_BIT = 0;
  localparam int unsigned PIN_FIVE = 5;
  // Pins that take part in change detection
  localparam logic [7:0] UPPER_CHANGE_PINS = 8'hf0;
  // Reset values and implemented-bit masks
  localparam logic [7:0] DIRECTION_RST = 8'hff;
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [7:0] INT_MAIN_RST = 8'h00;
  localparam logic [7:0] INT_SECOND_RST = 8'hf5;
  localparam logic [7:0] INT_SECOND_MASK = 8'hf5;
  localparam logic [7:0] INT_THIRD_RST = 8'hc0;
  localparam logic [7:0] INT_THIRD_MASK = 8'hdb;
  localparam logic PROG_ENABLE_RST = 1'b1;
  // Bus answer timing: ready raised one cycle after the setup cycle
  localparam int unsigned BUS_WAIT_CYCLES = 1;
endpackage

// ==== core/gpio_change_port.sv ====
// Eight-bit general-purpose port with change detection, APB slave
//
// What this block does
// R1 - Eight bidirectional pins, each with direction, latch and read bit.
// R2 - Direction bit one turns the pin driver off, making an input.
// R3 - Direction bit zero drives the latch value onto the pin.
// R4 - Latch register has its own address and reads back latch contents.
// R5 - Clearing the active-low pull-up bit enables all pull-ups together.
// R6 - A pin set as output never has its pull-up on.
// R7 - After reset pull-ups are off, the control bit reads one.
// R8 - Every reset sets all direction bits, so pins start as inputs.
// R9 - Only pins 7 to 4 compare, and outputs among them are skipped.
// R10 - Each compared pin is checked against a snapshot taken on port access.
// R11 - Mismatches are ORed to set the change flag, bit 0 main control.
// R12 - A change interrupt can wake the device from sleep.
// R13 - Port read or write refreshes the snapshot; memory moves do not.
// R14 - A lasting mismatch keeps setting the flag over software clears.
// R15 - Software should not poll the port when change detection is used.
// R16 - Low-voltage programming, on by default, takes pin five and its pull-up.
// R17 - Software making pin five an output must clear latch bit five.
// R18 - Bit 3 of main control enables the change interrupt.
// R19 - Bit 0 of the second control register selects its priority.
// R20 - Port reads return pin levels; port writes update the latch.
// R21 - Pin inputs pass two flops before reading and comparing.
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/100ps
module gpio_change_port
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [gpio_change_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mem_to_mem_move,
  input wire logic [gpio_change_pkg::PORT_W-1:0] pin_in,
  output logic [gpio_change_pkg::PORT_W-1:0] pin_out,
  output logic [gpio_change_pkg::PORT_W-1:0] pin_oe,
  output logic [gpio_change_pkg::PORT_W-1:0] pullup_en,
  output logic change_irq_high,
  output logic change_irq_low,
  output logic change_wake
);
  import gpio_change_pkg::*;

  logic [PORT_W-1:0] pin_meta;
  logic [PORT_W-1:0] pin_sync;
  logic [PORT_W-1:0] port_output_latch;
  logic [PORT_W-1:0] port_direction;
  logic [PORT_W-1:0] snapshot;
  logic [7:0] interrupt_control_main;
  logic [7:0] interrupt_control_second;
  logic [7:0] interrupt_control_third;
  logic low_voltage_programming;
  logic setup_phase;
  logic done;
  logic wr_done;
  logic rd_done;
  logic mapped;
  logic port_access;
  logic [PORT_W-1:0] diff_bits;
  logic mismatch;
  logic [7:0] next_rdata;
  logic [PORT_W-1:0] gpio_mask;
  logic [PORT_W-1:0] next_oe;
  logic [PORT_W-1:0] next_pullup;
  logic change_active;

  // Two-flop synchroniser; only pin_sync is read by logic   [R21]
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
    end
    else
    begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  // Bus phase decode; a transfer completes when ready is seen high
  assign setup_phase = psel && !penable;
  assign done = psel && penable && pready;
  assign wr_done = done && pwrite;
  assign rd_done = done && !pwrite;
  assign port_access = done && (paddr == ADDR_PIN_VALUE);

  // Address decode for read data; unmapped reads return zero
  always_comb
  begin
    mapped = 1'b1;
    next_rdata = 8'h00;
    if (paddr == ADDR_PIN_VALUE)
    begin
      next_rdata = pin_sync; // Pin levels, not the latch   [R20]
    end
    else if (paddr == ADDR_OUT_LATCH)
    begin
      next_rdata = port_output_latch; // Latch itself   [R4]
    end
    else if (paddr == ADDR_DIRECTION)
    begin
      next_rdata = port_direction;
    end
    else if (paddr == ADDR_INT_MAIN)
    begin
      next_rdata = interrupt_control_main;
    end
    else if (paddr == ADDR_INT_SECOND)
    begin
      next_rdata = interrupt_control_second & INT_SECOND_MASK;
    end
    else if (paddr == ADDR_INT_THIRD)
    begin
      next_rdata = interrupt_control_third & INT_THIRD_MASK;
    end
    else if (paddr == ADDR_PROG_CTRL)
    begin
      next_rdata = {7'h00, low_voltage_programming};
    end
    else
    begin
      mapped = 1'b0;
    end
  end

  // Answer one cycle after setup; data and error are held through access
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (setup_phase)
    begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, next_rdata};
      pslverr <= !mapped;
    end
    else if (done)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Port writes and latch writes both land in the latch   [R20] [R4]
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      port_output_latch <= LATCH_RST;
    end
    else if (wr_done && pstrb[0] &&
             (paddr == ADDR_PIN_VALUE || paddr == ADDR_OUT_LATCH))
    begin
      port_output_latch <= pwdata[7:0];
    end
  end

  // Every reset makes all pins inputs   [R8]
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      port_direction <= DIRECTION_RST;
    end
    else if (wr_done && pstrb[0] && paddr == ADDR_DIRECTION)
    begin
      port_direction <= pwdata[7:0];
    end
  end

  // Second and third control registers; pull-ups off at reset   [R7]
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      interrupt_control_second <= INT_SECOND_RST;
      interrupt_control_third <= INT_THIRD_RST;
    end
    else if (wr_done && pstrb[0])
    begin
      if (paddr == ADDR_INT_SECOND)
      begin
        interrupt_control_second <= pwdata[7:0] & INT_SECOND_MASK;
      end
      if (paddr == ADDR_INT_THIRD)
      begin
        interrupt_control_third <= pwdata[7:0] & INT_THIRD_MASK;
      end
    end
  end

  // Programming mode starts enabled and holds pin five   [R16]
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      low_voltage_programming <= PROG_ENABLE_RST;
    end
    else if (wr_done && pstrb[0] && paddr == ADDR_PROG_CTRL)
    begin
      low_voltage_programming <= pwdata[PROG_ENABLE_BIT];
    end
  end

  // Snapshot refreshed by any port access except a memory move [R10] [R13]
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      snapshot <= '0;
    end
    else if (port_access && !mem_to_mem_move)
    begin
      snapshot <= pin_sync;
    end
  end

  // Upper input pins only; outputs are left out of the compare   [R9]
  assign diff_bits = (pin_sync ^ snapshot) & port_direction &
                     UPPER_CHANGE_PINS;
  assign mismatch = |diff_bits; // OR of per-pin mismatches   [R11]

  // Main control: hardware set beats a software clear of the flag
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      interrupt_control_main <= INT_MAIN_RST;
    end
    else
    begin
      if (wr_done && pstrb[0] && paddr == ADDR_INT_MAIN)
      begin
        interrupt_control_main <= pwdata[7:0];
      end
      if (mismatch)
      begin
        interrupt_control_main[CHANGE_FLAG_BIT] <= 1'b1; // [R11] [R14]
      end
    end
  end

  // Pin five leaves general-purpose use while programming is enabled
  assign gpio_mask = low_voltage_programming ?
                     ~(8'h01 << PIN_FIVE) : 8'hff;
  // Driver on only for outputs   [R2] [R3]
  assign next_oe = ~port_direction & gpio_mask;
  // Global enable, inputs only, pin five excluded while programming   [R5] [R6] [R16]
  assign next_pullup = interrupt_control_second[PULLUP_DIS_N_BIT] ?
                       8'h00 : (port_direction & gpio_mask);

  // Pin drive registered so every output leaves a flop   [R1]
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      pin_out <= '0;
      pin_oe <= '0;
      pullup_en <= '0;
    end
    else
    begin
      pin_out <= port_output_latch; // [R3]
      pin_oe <= next_oe; // [R2]
      pullup_en <= next_pullup; // [R6]
    end
  end

  // Flag only reaches the requests while the enable bit is set   [R18]
  assign change_active = interrupt_control_main[CHANGE_FLAG_BIT] &&
                         interrupt_control_main[CHANGE_ENABLE_BIT];

  // Requests to the interrupt controller; wake does not need a clock edge
  // beyond this one, so sleep logic may gate the clock after seeing it
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      change_irq_high <= 1'b0;
      change_irq_low <= 1'b0;
      change_wake <= 1'b0;
    end
    else
    begin
      change_irq_high <= change_active &&
                         interrupt_control_second[CHANGE_PRIO_BIT]; // [R19]
      change_irq_low <= change_active &&
                        !interrupt_control_second[CHANGE_PRIO_BIT]; // [R18]
      change_wake <= change_active; // [R12]
    end
  end

  // Checks on the behaviour above
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  // Both sync flops are cleared by reset, so skip two edges after it
  AST_SYNC_DEPTH: assert property ( // [R21]
    ($past(rst_b) && $past(rst_b, 2)) |->
    pin_sync == $past(pin_in, 2))
    else $error("pin sync is not two cycles behind pin");

  AST_INPUT_HIGHZ: assert property ( // [R2]
    (pin_oe & $past(port_direction)) == 8'h00)
    else $error("input pin is driven");

  AST_OUTPUT_DRIVE: assert property ( // [R3]
    ($past(rst_b) && $past(low_voltage_programming) == 1'b0) |->
    (pin_oe == ~$past(port_direction) &&
     pin_out == $past(port_output_latch)))
    else $error("output pin does not drive latch");

  AST_LATCH_READ: assert property ( // [R4]
    (setup_phase && !pwrite && paddr == ADDR_OUT_LATCH) |=>
    (pready && prdata[7:0] == $past(port_output_latch)))
    else $error("latch read returned wrong value");

  AST_PULLUP_ALL: assert property ( // [R5]
    (!interrupt_control_second[PULLUP_DIS_N_BIT] &&
     !low_voltage_programming && port_direction == 8'hff) |=>
    (pullup_en == 8'hff))
    else $error("pull-ups not all enabled");

  AST_PULLUP_OUTPUT: assert property ( // [R6]
    (pullup_en & ~$past(port_direction)) == 8'h00)
    else $error("pull-up on while pin is output");

  AST_RESET_STATE: assert property (disable iff (1'b0) // [R7] [R8]
    @(posedge core_clk) !rst_b |=>
    (port_direction == DIRECTION_RST &&
     interrupt_control_second[PULLUP_DIS_N_BIT] &&
     low_voltage_programming))
    else $error("reset state wrong");

  AST_FLAG_SET: assert property ( // [R11] [R14]
    mismatch |=> interrupt_control_main[CHANGE_FLAG_BIT])
    else $error("mismatch did not set change flag");

  AST_LOWER_IGNORED: assert property ( // [R9]
    ((pin_sync ^ snapshot) & (~port_direction | ~UPPER_CHANGE_PINS)) ==
    (pin_sync ^ snapshot) |-> !mismatch)
    else $error("excluded pin caused a mismatch");

  AST_SNAP_REFRESH: assert property ( // [R13]
    (port_access && !mem_to_mem_move) |=> snapshot == $past(pin_sync))
    else $error("port access did not refresh snapshot");

  AST_SNAP_MOVE: assert property ( // [R13]
    (port_access && mem_to_mem_move) |=> $stable(snapshot))
    else $error("memory move refreshed snapshot");

  AST_PROG_PIN5: assert property ( // [R16]
    low_voltage_programming |=> (!pin_oe[PIN_FIVE] &&
                                 !pullup_en[PIN_FIVE]))
    else $error("pin five used while programming enabled");

  AST_IRQ_PRIO: assert property ( // [R18] [R19]
    change_active |=>
    (change_irq_high == $past(interrupt_control_second[CHANGE_PRIO_BIT])
     && change_irq_low != change_irq_high && change_wake))
    else $error("change interrupt request wrong");

  COV_CHANGE_IRQ: cover property (mismatch ##[1:4] change_wake);
  COV_PORT_READ: cover property (port_access && !pwrite ##1 !mismatch);
  COV_MOVE_READ: cover property (port_access && mem_to_mem_move);
  COV_CLEAR_HELD: cover property (
    wr_done && paddr == ADDR_INT_MAIN && mismatch);
endmodule

// ==== bench/pin_board.sv ====
// Board model: pin wires with device drivers, key drivers and pull-ups
`timescale 1ns/100ps
module pin_board
(
  input wire logic core_clk,
  input wire logic [gpio_change_pkg::PORT_W-1:0] pin_out,
  input wire logic [gpio_change_pkg::PORT_W-1:0] pin_oe,
  input wire logic [gpio_change_pkg::PORT_W-1:0] pullup_en,
  input wire logic [gpio_change_pkg::PORT_W-1:0] ext_val,
  input wire logic [gpio_change_pkg::PORT_W-1:0] ext_en,
  output logic [gpio_change_pkg::PORT_W-1:0] pin_in
);
  import gpio_change_pkg::*;

  logic [PORT_W-1:0] float_q = '0;
  // A bare wire has no defined level, so it wanders every cycle
  always @(posedge core_clk)
    float_q <= ~pin_in;
  // Device driver wins, then the board, then the weak pull-up
  always_comb
    for (int i = 0; i < PORT_W; i++)
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
        pullup_en[i] ? 1'b1 : float_q[i];
endmodule

// ==== bench/test_gpio_port_with_change_interrupt.sv ====
// Self-checking bench for the port with change detection
`timescale 1ns/100ps
module test_gpio_port_with_change_interrupt;
  import gpio_change_pkg::*;
  logic core_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic mem_to_mem_move = 0, pready, pslverr, err;
  logic [7:0] paddr = '0, ext_val = '0, ext_en = '1, dir, lat, ev;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic [PORT_W-1:0] pin_in, pin_out, pin_oe, pullup_en;
  logic change_irq_high, change_irq_low, change_wake;
  int n_fail = 0, checks_done = 0;

  // 200 MHz clock
  always #2.5 core_clk = ~core_clk;

  gpio_change_port DUT (.core_clk, .rst_b, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .mem_to_mem_move,
    .pin_in, .pin_out, .pin_oe, .pullup_en, .change_irq_high,
    .change_irq_low, .change_wake);

  pin_board board (.core_clk, .pin_out, .pin_oe, .pullup_en, .ext_val,
    .ext_en, .pin_in);

  task automatic report_and_stop();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; an idle edge first so no signal is set twice
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic mm);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    mem_to_mem_move <= mm;
    @(posedge core_clk);
    penable <= 1'b1;
    // Access held until ready; only the watchdog ends a hang
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    mem_to_mem_move <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 1'b0);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, 1'b0);
    chk(rd, e);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Bounded wait for the wake level
  task automatic wait_wake();
    for (int i = 0; i < 20 && change_wake !== 1'b1; i++)
      @(posedge core_clk);
  endtask

  // Inputs show the board, outputs show the latch
  function automatic logic [7:0] pins_exp(input logic [7:0] d, l, e);
    return (d & e) | (~d & l);
  endfunction

  // Watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    #20000;
    n_fail++;
    report_and_stop();
  end

  // Main sequence
  initial
  begin
    void'($urandom(28908));
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    rdc(ADDR_DIRECTION, 32'hff);
    rdc(ADDR_INT_SECOND, 32'hf5);
    chk(pin_oe, 8'h00);
    chk(pullup_en, 8'h00);
    xfer(1'b0, 8'h40, 32'h0, 1'b0);
    chk(err, 1'b1);
    wr(ADDR_PROG_CTRL, 32'h0);
    // Random latch, direction and board levels
    repeat (6)
    begin
      lat = 8'($urandom);
      dir = 8'($urandom);
      ev = 8'($urandom);
      ext_val <= ev;
      wr(ADDR_PIN_VALUE, {24'h0, lat});
      wr(ADDR_DIRECTION, {24'h0, dir});
      cyc(4);
      chk(pin_oe, 8'(~dir));
      chk(pin_out & ~dir, lat & ~dir);
      rdc(ADDR_OUT_LATCH, {24'h0, lat});
      rdc(ADDR_PIN_VALUE, {24'h0, pins_exp(dir, lat, ev)});
    end
    // Pull-ups hold undriven inputs high
    wr(ADDR_DIRECTION, 32'hff);
    wr(ADDR_INT_SECOND, 32'h75);
    ext_val <= 8'h05;
    ext_en <= 8'h0f;
    cyc(4);
    chk(pullup_en, 8'hff);
    rdc(ADDR_PIN_VALUE, 32'hf5);
    ext_en <= 8'hff;
    wr(ADDR_DIRECTION, 32'h3c);
    cyc(3);
    chk(pullup_en, 8'h3c);
    wr(ADDR_PIN_VALUE, {24'h0, lat & 8'hdf});
    wr(ADDR_PROG_CTRL, 32'h1);
    cyc(3);
    chk(pullup_en, 8'h1c);
    wr(ADDR_DIRECTION, 32'hc3);
    cyc(3);
    chk(pin_oe, 8'h1c);
    // Change detection; no polling between events
    wr(ADDR_PROG_CTRL, 32'h0);
    wr(ADDR_DIRECTION, 32'h7f);
    ext_val <= 8'h00;
    wr(ADDR_PIN_VALUE, 32'h0);
    cyc(4);
    rdc(ADDR_PIN_VALUE, 32'h00);
    wr(ADDR_INT_MAIN, 32'h08);
    ext_val <= 8'h0f;
    wr(ADDR_OUT_LATCH, 32'h80);
    cyc(8);
    chk(change_wake, 1'b0);
    ext_val <= 8'h4f;
    wait_wake();
    chk(change_wake, 1'b1);
    chk({change_irq_high, change_irq_low}, 2'b10);
    rdc(ADDR_INT_MAIN, 32'h09);
    wr(ADDR_INT_MAIN, 32'h08);
    rdc(ADDR_INT_MAIN, 32'h09);
    xfer(1'b0, ADDR_PIN_VALUE, 32'h0, 1'b1);
    wr(ADDR_INT_MAIN, 32'h08);
    rdc(ADDR_INT_MAIN, 32'h09);
    rdc(ADDR_PIN_VALUE, 32'hcf);
    wr(ADDR_INT_MAIN, 32'h08);
    rdc(ADDR_INT_MAIN, 32'h08);
    chk(change_wake, 1'b0);
    wr(ADDR_INT_SECOND, 32'h74);
    ext_val <= 8'h0f;
    wait_wake();
    chk({change_irq_high, change_irq_low}, 2'b01);
    // A second reset in mid-run
    rst_b <= 1'b0;
    cyc(1);
    rst_b <= 1'b1;
    rdc(ADDR_DIRECTION, 32'hff);
    rdc(ADDR_INT_SECOND, 32'hf5);
    report_and_stop();
  end
endmodule
